// file: logic/enc_diag_pkg.sv
// Package for the encoder diagnostic register bank: register indexes,
// field layout, reset values, command codes and timing constants.
// Assumes a 125 MHz APB clock; the register index is the word index.
package enc_diag_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [6:0] IDX_COMMAND      = 7'h48;
  localparam logic [6:0] IDX_ST_BITS      = 7'h56;
  localparam logic [6:0] IDX_MT_BITS      = 7'h57;
  localparam logic [6:0] IDX_ANALOG_RES   = 7'h58;
  localparam logic [6:0] IDX_USAGE_COUNT  = 7'h59;
  localparam logic [6:0] IDX_USAGE_LIMIT  = 7'h5D;
  localparam logic [6:0] IDX_ACCEL_VALUE  = 7'h60;
  localparam logic [6:0] IDX_ACCEL_LIMIT  = 7'h63;
  localparam logic [6:0] IDX_RATE_VALUE   = 7'h66;
  localparam logic [6:0] IDX_RATE_LIMIT   = 7'h68;
  localparam logic [6:0] IDX_FAULT_FLAGS  = 7'h74;
  localparam int         ADDR_LSB         = 2;

  // Command codes
  localparam logic [7:0] CMD_CLEAR_DIAG   = 8'h08;

  // Fixed descriptor defaults
  localparam logic [7:0] ST_BITS_DEFAULT  = 8'h11;
  localparam logic [7:0] MT_BITS_DEFAULT  = 8'h0C;
  localparam logic [7:0] ANALOG_NONE      = 8'h00;
  localparam logic [7:0] ANALOG_1024      = 8'h11;

  // Fault flag bit positions
  localparam int FLAG_USAGE     = 0;
  localparam int FLAG_ACCEL     = 1;
  localparam int FLAG_RATE      = 2;
  localparam int FLAG_SAVE_FAIL = 4;

  // Acceleration word layout
  localparam int ACCEL_MAG_W    = 18;
  localparam int ACCEL_SIGN_BIT = 23;

  // Limit reset values
  localparam logic [23:0] USAGE_LIMIT_RST = 24'h000000;
  localparam logic [23:0] ACCEL_LIMIT_RST = 24'h000000;
  localparam logic [15:0] RATE_LIMIT_RST  = 16'h0000;

  // Sampling: 7.8125 ms at 125 MHz, rounded down to whole cycles
  localparam real SAMPLE_PERIOD_NS  = 7812500.0;
  localparam real CLK_PERIOD_NS     = 8.0;
  localparam int  SAMPLE_CYCLES_DOC = int'($floor(SAMPLE_PERIOD_NS / CLK_PERIOD_NS));
  localparam int  SAMPLES_PER_SEC   = 128;
  localparam int  ACCEL_STEP_RPMS   = 30;
  localparam logic [15:0] RATE_MAX_RPM = 16'h1C9C;

  // Usage counting: revolutions per cycle and hysteresis, in revolutions
  localparam int REVS_PER_CYCLE = 2;
  localparam int HYST_REVS      = 1;

  typedef enum logic [1:0] {NV_LOAD, NV_RUN, NV_SAVE, NV_HALT} nv_state_t;

endpackage : enc_diag_pkg

// file: logic/encoder_diagnostic_registers.sv
// Diagnostic register bank of a multiturn absolute encoder: resolution
// descriptors, non-volatile usage counter, acceleration and speed monitors.
// Assumes an APB master on pclk, a revolution step source, a speed sample
// source and a non-volatile store with a load and a save handshake.
//
// Summary of operation
// RULE1: Read-only byte with single-turn bit count
// RULE2: Read-only byte with turn-count bit count
// RULE3: Analog track code byte, default 11h
// RULE4: Usage counter counts up every two turns
// RULE5: One revolution hysteresis around counter increments
// RULE6: Load count at power-up, save at loss
// RULE7: Failed save restores count, sets bit four
// RULE8: Usage count read as 32-bit, MSB first
// RULE9: Usage limit reached sets flag bit zero
// RULE10: Zero usage limit disables warning; resets zero
// RULE11: Acceleration magnitude 18 bits, bits 18-22 zero
// RULE12: Top acceleration bit shows speeding up
// RULE13: Zero limit shows live, else peak acceleration
// RULE14: Acceleration every 7.8125 ms, 30 RPM/s steps
// RULE15: Acceleration limit reached sets flag bit one
// RULE16: Command 08 clears acceleration and speed peaks
// RULE17: Speed sampled every 7.8125 ms, 16-bit RPM
// RULE18: Zero speed limit shows live, else peak
// RULE19: Speed limit reached sets flag bit two
// RULE20: Command 08 clears flags; persistent causes reassert
// RULE21: Limit reached means value at or above
// RULE22: Peak updates only on larger sample
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module encoder_diagnostic_registers
  import enc_diag_pkg::*;
#(
  parameter int          SAMPLE_CYCLES = SAMPLE_CYCLES_DOC,
  parameter int          STEPS_PER_REV = 4,
  parameter logic [7:0]  ST_BITS       = ST_BITS_DEFAULT,
  parameter logic [7:0]  MT_BITS       = MT_BITS_DEFAULT,
  parameter logic [7:0]  ANALOG_RES    = ANALOG_1024
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Shaft motion
  input  wire logic        step_pulse,
  input  wire logic        step_forward,
  input  wire logic [15:0] rate_sample,
  // Non-volatile store
  input  wire logic        nv_load_valid,
  input  wire logic [31:0] nv_load_count,
  input  wire logic        power_fail,
  output logic             nv_save_req,
  output logic      [31:0] nv_save_count,
  input  wire logic        nv_save_done,
  input  wire logic        nv_save_ok
);

  localparam int RUN_W = 16;
  localparam logic [RUN_W-1:0] CYCLE_STEPS = RUN_W'(REVS_PER_CYCLE * STEPS_PER_REV);
  localparam logic [RUN_W-1:0] HYST_STEPS  = RUN_W'(HYST_REVS * STEPS_PER_REV);
  localparam logic [19:0]      SAMPLE_LAST = 20'(SAMPLE_CYCLES - 1);
  localparam logic [17:0]      ACCEL_MAX   = {ACCEL_MAG_W{1'b1}};

  // Word index of an APB address; unaligned low bits are ignored
  function automatic logic [6:0] word_index(input logic [11:0] addr);
    word_index = addr[ADDR_LSB +: 7];
  endfunction : word_index

  function automatic logic is_mapped(input logic [6:0] idx);
    is_mapped = (idx == IDX_COMMAND)     || (idx == IDX_ST_BITS)     ||
                (idx == IDX_MT_BITS)     || (idx == IDX_ANALOG_RES)  ||
                (idx == IDX_USAGE_COUNT) || (idx == IDX_USAGE_LIMIT) ||
                (idx == IDX_ACCEL_VALUE) || (idx == IDX_ACCEL_LIMIT) ||
                (idx == IDX_RATE_VALUE)  || (idx == IDX_RATE_LIMIT)  ||
                (idx == IDX_FAULT_FLAGS);
  endfunction : is_mapped

  logic [31:0]      usage_cycle_count_reg;
  logic [31:0]      saved_count_reg;
  logic [23:0]      usage_cycle_threshold_reg;
  logic [23:0]      accel_threshold_reg;
  logic [15:0]      rotation_rate_threshold_reg;
  logic [17:0]      accel_live_reg;
  logic [17:0]      accel_peak_reg;
  logic             accel_up_reg;
  logic             accel_peak_up_reg;
  logic [15:0]      rate_live_reg;
  logic [15:0]      rate_peak_reg;
  logic [15:0]      rate_prev_reg;
  logic [7:0]       fault_flags_reg;
  logic [19:0]      sample_cnt_reg;
  logic             sample_tick;
  logic [RUN_W-1:0] run_reg;
  logic             run_fwd_reg;
  logic             armed_reg;
  logic             usage_inc;
  logic             save_failed;
  nv_state_t        nv_state_reg;

  logic        wr_en;
  logic        clear_cmd;
  logic [6:0]  wr_idx;
  logic [15:0] rate_clamped;
  logic [15:0] rate_delta;
  logic [23:0] accel_raw;
  logic [17:0] accel_quant;
  logic [23:0] accel_word;
  logic [15:0] rate_word;
  logic        usage_hit;
  logic        accel_hit;
  logic        rate_hit;

  // A write takes effect at the edge that completes the access phase
  assign wr_idx    = word_index(paddr);
  assign wr_en     = psel && penable && pready && pwrite;
  assign clear_cmd = wr_en && (wr_idx == IDX_COMMAND) &&
                     (pwdata[7:0] == CMD_CLEAR_DIAG);           // RULE16

  // APB handshake: one wait-free access phase, error for unmapped words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !is_mapped(word_index(paddr));
    end
  end

  // Read data is captured in setup so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (word_index(paddr))
        IDX_ST_BITS:     prdata <= {24'h000000, ST_BITS};                     // RULE1
        IDX_MT_BITS:     prdata <= {24'h000000, MT_BITS};                     // RULE2
        IDX_ANALOG_RES:  prdata <= {24'h000000, ANALOG_RES};                  // RULE3
        IDX_USAGE_COUNT: prdata <= usage_cycle_count_reg;                     // RULE8
        IDX_USAGE_LIMIT: prdata <= {8'h00, usage_cycle_threshold_reg};
        IDX_ACCEL_VALUE: prdata <= {8'h00, accel_word};
        IDX_ACCEL_LIMIT: prdata <= {8'h00, accel_threshold_reg};
        IDX_RATE_VALUE:  prdata <= {16'h0000, rate_word};
        IDX_RATE_LIMIT:  prdata <= {16'h0000, rotation_rate_threshold_reg};
        IDX_FAULT_FLAGS: prdata <= {24'h000000, fault_flags_reg};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  // Limit registers; only the low bits of the written word are kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usage_cycle_threshold_reg   <= USAGE_LIMIT_RST;               // RULE10
      accel_threshold_reg         <= ACCEL_LIMIT_RST;
      rotation_rate_threshold_reg <= RATE_LIMIT_RST;
    end else if (wr_en) begin
      if (wr_idx == IDX_USAGE_LIMIT) usage_cycle_threshold_reg <= pwdata[23:0];
      if (wr_idx == IDX_ACCEL_LIMIT) accel_threshold_reg <= pwdata[23:0];
      if (wr_idx == IDX_RATE_LIMIT)  rotation_rate_threshold_reg <= pwdata[15:0];
    end
  end

  // Sample period divider: one-cycle tick every sampling period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cnt_reg <= 20'h00000;
      sample_tick    <= 1'b0;
    end else begin
      sample_tick    <= (sample_cnt_reg == SAMPLE_LAST);        // RULE14 RULE17
      sample_cnt_reg <= (sample_cnt_reg == SAMPLE_LAST) ? 20'h00000 : sample_cnt_reg + 20'h00001;
    end
  end

  // Speed saturates at the measurable top; acceleration from speed change
  assign rate_clamped = (rate_sample > RATE_MAX_RPM) ? RATE_MAX_RPM : rate_sample;  // RULE17
  assign rate_delta   = (rate_clamped >= rate_prev_reg) ? rate_clamped - rate_prev_reg
                                                        : rate_prev_reg - rate_clamped;
  assign accel_raw    = 24'(rate_delta) * 24'(SAMPLES_PER_SEC);
  // Integer division by a constant truncates to the lower 30 RPM/s step
  assign accel_quant  = (accel_raw > 24'(ACCEL_MAX)) ? ACCEL_MAX :
                        18'((accel_raw / 24'(ACCEL_STEP_RPMS)) * 24'(ACCEL_STEP_RPMS));  // RULE14

  // Live samples, taken once per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_live_reg  <= 16'h0000;
      rate_prev_reg  <= 16'h0000;
      accel_live_reg <= 18'h00000;
      accel_up_reg   <= 1'b0;
    end else if (sample_tick) begin
      rate_live_reg  <= rate_clamped;
      rate_prev_reg  <= rate_clamped;
      accel_live_reg <= accel_quant;
      accel_up_reg   <= (rate_clamped > rate_prev_reg);         // RULE12
    end
  end

  // Peaks grow only on a larger sample; the clear command restarts capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accel_peak_reg    <= 18'h00000;
      accel_peak_up_reg <= 1'b0;
      rate_peak_reg     <= 16'h0000;
    end else if (clear_cmd) begin
      accel_peak_reg    <= 18'h00000;                           // RULE16
      accel_peak_up_reg <= 1'b0;
      rate_peak_reg     <= 16'h0000;
    end else begin
      if (accel_live_reg > accel_peak_reg) begin                // RULE22
        accel_peak_reg    <= accel_live_reg;
        accel_peak_up_reg <= accel_up_reg;
      end
      if (rate_live_reg > rate_peak_reg)                        // RULE22
        rate_peak_reg <= rate_live_reg;
    end
  end

  // Shown words pick live or peak by whether the limit is armed
  assign accel_word = (accel_threshold_reg == 24'h000000)
                      ? {accel_up_reg, 5'h00, accel_live_reg}                  // RULE13 RULE11
                      : {accel_peak_up_reg, 5'h00, accel_peak_reg};            // RULE13 RULE11
  assign rate_word  = (rotation_rate_threshold_reg == 16'h0000) ? rate_live_reg
                                                                : rate_peak_reg; // RULE18

  // Limit reached means at or above; a zero limit never fires
  assign usage_hit = (usage_cycle_threshold_reg != 24'h000000) &&
                     (usage_cycle_count_reg >= {8'h00, usage_cycle_threshold_reg}); // RULE9 RULE10 RULE21
  assign accel_hit = (accel_threshold_reg != 24'h000000) &&
                     ({6'h00, accel_live_reg} >= accel_threshold_reg);          // RULE15 RULE21
  assign rate_hit  = (rotation_rate_threshold_reg != 16'h0000) &&
                     (rate_live_reg >= rotation_rate_threshold_reg);            // RULE19 RULE21

  // Fault flags: a cause present in the clearing cycle still sets its bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flags_reg <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (clear_cmd) fault_flags_reg[i] <= 1'b0;              // RULE20
      end
      if (usage_hit)   fault_flags_reg[FLAG_USAGE]     <= 1'b1; // RULE9
      if (accel_hit)   fault_flags_reg[FLAG_ACCEL]     <= 1'b1; // RULE15
      if (rate_hit)    fault_flags_reg[FLAG_RATE]      <= 1'b1; // RULE19
      if (save_failed) fault_flags_reg[FLAG_SAVE_FAIL] <= 1'b1; // RULE7
    end
  end

  // Usage travel tracking: two turns per cycle in either direction; a
  // reversal longer than one turn arms a one-turn threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg     <= '0;
      run_fwd_reg <= 1'b1;
      armed_reg   <= 1'b0;
    end else if (step_pulse && (nv_state_reg == NV_RUN)) begin
      if (step_forward != run_fwd_reg) begin
        run_fwd_reg <= step_forward;
        run_reg     <= RUN_W'(1);
        armed_reg   <= (run_reg > HYST_STEPS);                  // RULE5
      end else if (usage_inc) begin
        run_reg   <= '0;
        armed_reg <= 1'b0;
      end else begin
        run_reg <= run_reg + RUN_W'(1);
      end
    end
  end

  // Increment when the run in one direction completes its threshold
  assign usage_inc = step_pulse && (nv_state_reg == NV_RUN) &&
                     (step_forward == run_fwd_reg) &&
                     ((run_reg + RUN_W'(1)) > (armed_reg ? HYST_STEPS : CYCLE_STEPS - RUN_W'(1))); // RULE4 RULE5

  // Power sequence: load at start, count, save on loss, then halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_state_reg <= NV_LOAD;
    end else begin
      unique case (nv_state_reg)
        NV_LOAD: if (nv_load_valid) nv_state_reg <= NV_RUN;     // RULE6
        NV_RUN:  if (power_fail)    nv_state_reg <= NV_SAVE;    // RULE6
        NV_SAVE: if (nv_save_done)  nv_state_reg <= NV_HALT;
        NV_HALT: nv_state_reg <= NV_HALT;
      endcase
    end
  end

  assign save_failed = (nv_state_reg == NV_SAVE) && nv_save_done && !nv_save_ok;

  // Save request and its data are held until the store answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_save_req   <= 1'b0;
      nv_save_count <= 32'h00000000;
    end else if ((nv_state_reg == NV_RUN) && power_fail) begin
      nv_save_req   <= 1'b1;                                    // RULE6
      nv_save_count <= usage_inc ? usage_cycle_count_reg + 32'h00000001
                                 : usage_cycle_count_reg;
    end else if (nv_save_done) begin
      nv_save_req   <= 1'b0;
    end
  end

  // Working count and last good saved copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usage_cycle_count_reg <= 32'h00000000;
      saved_count_reg       <= 32'h00000000;
    end else begin
      unique case (nv_state_reg)
        NV_LOAD: if (nv_load_valid) begin
          usage_cycle_count_reg <= nv_load_count;               // RULE6
          saved_count_reg       <= nv_load_count;
        end
        NV_RUN: if (usage_inc && (usage_cycle_count_reg != 32'hFFFFFFFF))
          usage_cycle_count_reg <= usage_cycle_count_reg + 32'h00000001; // RULE4
        NV_SAVE: if (nv_save_done) begin
          if (nv_save_ok) saved_count_reg <= nv_save_count;
          else usage_cycle_count_reg <= saved_count_reg;        // RULE7
        end
        NV_HALT: usage_cycle_count_reg <= usage_cycle_count_reg;
      endcase
    end
  end

endmodule : encoder_diagnostic_registers

// file: bench/enc_diag_sva.sv
// Checker for the encoder diagnostic register bank, bound to its ports.
// Assumes zero-wait APB reads whose data stand in the access phase.
`timescale 1ns/100ps
module enc_diag_sva
  import enc_diag_pkg::*;
#(
  parameter logic [7:0] ST_BITS    = ST_BITS_DEFAULT,
  parameter logic [7:0] MT_BITS    = MT_BITS_DEFAULT,
  parameter logic [7:0] ANALOG_RES = ANALOG_1024
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Non-volatile store
  input wire logic        power_fail,
  input wire logic        nv_save_req,
  input wire logic [31:0] nv_save_count,
  input wire logic        nv_save_done
);
  logic [6:0] rd_idx;

  // Index of a read setup; 7F is unmapped and stands for no read
  assign rd_idx = (psel && !penable && !pwrite && paddr[11:9] == 3'h0 && paddr[1:0] == 2'h0)
                  ? paddr[8:2] : 7'h7F;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  st_bits_a: assert property (rd_idx == IDX_ST_BITS |=> prdata == {24'h0, ST_BITS})
    else $error("single-turn bit count wrong");
  mt_bits_a: assert property (rd_idx == IDX_MT_BITS |=> prdata == {24'h0, MT_BITS})
    else $error("turn bit count wrong");
  analog_res_a: assert property (rd_idx == IDX_ANALOG_RES |=> prdata[31:0] == {24'h0, ANALOG_RES})
    else $error("analog resolution wrong");
  accel_unused_a: assert property (rd_idx == IDX_ACCEL_VALUE |=>
    prdata[31:24] == 8'h0 && prdata[22:18] == 5'h0) else $error("accel unused bits set");
  rate_range_a: assert property (rd_idx == IDX_RATE_VALUE |=> prdata <= {16'h0, RATE_MAX_RPM})
    else $error("rate above range");
  flag_unused_a: assert property (rd_idx == IDX_FAULT_FLAGS |=>
    prdata[31:5] == 27'h0 && !prdata[3]) else $error("unused flag bit set");
  // A save only ever starts from a power loss and keeps its count steady
  save_cause_a: assert property ($rose(nv_save_req) |-> $past(power_fail))
    else $error("save without power loss");
  save_hold_a: assert property (nv_save_req && !nv_save_done |=> nv_save_req && $stable(nv_save_count))
    else $error("save request dropped early");
  save_end_a: assert property (nv_save_req && nv_save_done |=> !nv_save_req)
    else $error("save request stuck");

  save_seen_c: cover property ($rose(nv_save_req));
  err_seen_c: cover property (pready && pslverr);
  clear_seen_c: cover property (psel && penable && pwrite && paddr[8:2] == IDX_COMMAND);
endmodule : enc_diag_sva

bind encoder_diagnostic_registers enc_diag_sva #(
  .ST_BITS(ST_BITS), .MT_BITS(MT_BITS), .ANALOG_RES(ANALOG_RES)
) chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .power_fail(power_fail), .nv_save_req(nv_save_req), .nv_save_count(nv_save_count),
  .nv_save_done(nv_save_done));

// file: bench/nv_store_model.sv
// Model of the non-volatile store that keeps the usage count.
// Assumes one load after each reset; the stored count survives reset.
`timescale 1ns/100ps
module nv_store_model #(
  parameter logic [31:0] INIT_COUNT = 32'h00000000
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench controls: failed write, answer delay
  input  wire logic        fail_save,
  input  wire logic [3:0]  delay,
  // Store handshake
  output logic             nv_load_valid,
  output logic      [31:0] nv_load_count,
  input  wire logic        nv_save_req,
  input  wire logic [31:0] nv_save_count,
  output logic             nv_save_done,
  output logic             nv_save_ok
);
  logic [31:0] stored_reg;
  logic [3:0]  wait_reg;
  logic        loaded_reg;

  initial stored_reg = INIT_COUNT;
  // Released count lines show the inverse, never a stale copy
  assign nv_load_count = nv_load_valid ? stored_reg : ~stored_reg;

  // Load once after reset, then answer each save after the set delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg      <= 4'h0;
      loaded_reg    <= 1'b0;
      nv_load_valid <= 1'b0;
      nv_save_done  <= 1'b0;
      nv_save_ok    <= 1'b0;
    end else begin
      nv_load_valid <= 1'b0;
      nv_save_done  <= 1'b0;
      nv_save_ok    <= ~nv_save_ok;
      if ((!loaded_reg || (nv_save_req && !nv_save_done)) && wait_reg != delay) begin
        wait_reg <= wait_reg + 4'h1;
      end else if (!loaded_reg) begin
        wait_reg      <= 4'h0;
        loaded_reg    <= 1'b1;
        nv_load_valid <= 1'b1;
      end else if (nv_save_req && !nv_save_done) begin
        wait_reg     <= 4'h0;
        nv_save_done <= 1'b1;
        nv_save_ok   <= !fail_save;
        if (!fail_save) begin
          stored_reg <= nv_save_count;
        end
      end
    end
  end
endmodule : nv_store_model

// file: bench/encoder_diagnostic_registers_tb.sv
// Self-checking bench for the encoder diagnostic register bank.
// Assumes a zero-wait APB slave and a shortened sampling period.
`timescale 1ns/100ps
module encoder_diagnostic_registers_tb
  import enc_diag_pkg::*;
;
  localparam int          SC   = 16;
  localparam int          SPR  = 4;
  localparam logic [31:0] INIT = 32'h00A1B2C3;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        step_pulse, step_forward, power_fail, fail_save, ld_v, sv_req, sv_done, sv_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ld_cnt, sv_cnt, r;
  logic [15:0] rate_sample;
  logic [3:0]  delay;
  logic        e;
  int          err_total, n_compared, cyc;

  encoder_diagnostic_registers #(.SAMPLE_CYCLES(SC), .STEPS_PER_REV(SPR)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_pulse(step_pulse), .step_forward(step_forward), .rate_sample(rate_sample),
    .nv_load_valid(ld_v), .nv_load_count(ld_cnt), .power_fail(power_fail),
    .nv_save_req(sv_req), .nv_save_count(sv_cnt), .nv_save_done(sv_done), .nv_save_ok(sv_ok));
  nv_store_model #(.INIT_COUNT(INIT)) nv (.pclk(pclk), .presetn(presetn),
    .fail_save(fail_save), .delay(delay), .nv_load_valid(ld_v), .nv_load_count(ld_cnt),
    .nv_save_req(sv_req), .nv_save_count(sv_cnt), .nv_save_done(sv_done), .nv_save_ok(sv_ok));

  task automatic final_report();
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [6:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {3'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string what, input logic [6:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(what, r, exp);
  endtask : rd_chk

  task automatic clr();
    apb(1'b1, IDX_COMMAND, {24'h0, CMD_CLEAR_DIAG});
  endtask : clr

  task automatic steps(input int n, input logic fwd);
    repeat (n) begin
      @(posedge pclk);
      step_pulse   <= 1'b1;
      step_forward <= fwd;
      @(posedge pclk);
      step_pulse   <= 1'b0;
    end
  endtask : steps

  // New speed, then three sampling ticks so value, peak and flags settle
  task automatic rate(input logic [15:0] v);
    @(posedge pclk);
    rate_sample <= v;
    repeat (3 * SC) @(posedge pclk);
  endtask : rate

  task automatic pfail();
    @(posedge pclk);
    power_fail <= 1'b1;
    @(posedge pclk);
    power_fail <= 1'b0;
    do @(posedge pclk); while (sv_done !== 1'b1);
    repeat (2) @(posedge pclk);
  endtask : pfail

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    do @(posedge pclk); while (ld_v !== 1'b1);
  endtask : do_reset

  task automatic t_reset();
    rd_chk("st bits", IDX_ST_BITS, {24'h0, ST_BITS_DEFAULT});
    rd_chk("mt bits", IDX_MT_BITS, {24'h0, MT_BITS_DEFAULT});
    apb(1'b1, IDX_ANALOG_RES, 32'h00);
    rd_chk("analog", IDX_ANALOG_RES, 32'h11);
    rd_chk("usage lim", IDX_USAGE_LIMIT, 32'h0);
    rd_chk("accel lim", IDX_ACCEL_LIMIT, 32'h0);
    rd_chk("rate lim", IDX_RATE_LIMIT, 32'h0);
    rd_chk("usage load", IDX_USAGE_COUNT, INIT);
    apb(1'b0, 7'h10, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
  endtask : t_reset

  // Forward counting, and the one-turn hysteresis after a reversal
  task automatic t_usage();
    steps(2 * SPR, 1'b1);
    rd_chk("usage fwd", IDX_USAGE_COUNT, INIT + 1);
    steps(SPR + 1, 1'b0);
    steps(SPR + 1, 1'b1);
    rd_chk("usage hyst", IDX_USAGE_COUNT, INIT + 2);
    steps(SPR - 1, 1'b0);
    steps(2 * SPR - 1, 1'b1);
    rd_chk("usage short", IDX_USAGE_COUNT, INIT + 2);
    apb(1'b1, IDX_USAGE_LIMIT, INIT + 3);
    rd_chk("flag below", IDX_FAULT_FLAGS, 32'h0);
    steps(2 * SPR, 1'b1);
    rd_chk("flag usage", IDX_FAULT_FLAGS, 32'h1);
    clr();
    rd_chk("flag kept", IDX_FAULT_FLAGS, 32'h1);
    apb(1'b1, IDX_USAGE_LIMIT, 32'h0);
    clr();
    rd_chk("flag off", IDX_FAULT_FLAGS, 32'h0);
  endtask : t_usage

  // Peak capture, 30 RPM/s steps and limit flags of both monitors
  task automatic t_motion();
    rate(16'h0064);
    rd_chk("rate live", IDX_RATE_VALUE, 32'h64);
    apb(1'b1, IDX_ACCEL_LIMIT, 32'h3FFFF);
    clr();
    rate(16'h006E);
    rate(16'h0064);
    rate(16'h0069);
    apb(1'b0, IDX_ACCEL_VALUE, 32'h0);
    check("accel peak", r, 32'h008004EC);
    apb(1'b1, IDX_ACCEL_LIMIT, 32'h780);
    rate(16'h0078);
    rd_chk("flag accel", IDX_FAULT_FLAGS, 32'h2);
    clr();
    rd_chk("flag gone", IDX_FAULT_FLAGS, 32'h0);
    apb(1'b0, IDX_ACCEL_VALUE, 32'h0);
    check("accel clr", r, 32'h0);
    apb(1'b1, IDX_ACCEL_LIMIT, 32'h0);
    apb(1'b1, IDX_RATE_LIMIT, 32'hC8);
    rate(16'h0096);
    rate(16'h0082);
    rd_chk("rate peak", IDX_RATE_VALUE, 32'h96);
    rate(16'h00FA);
    rd_chk("flag rate", IDX_FAULT_FLAGS, 32'h4);
    rate(16'h00D2);
    clr();
    rd_chk("rate clr", IDX_RATE_VALUE, 32'hD2);
    rd_chk("flag back", IDX_FAULT_FLAGS, 32'h4);
    apb(1'b1, IDX_RATE_LIMIT, 32'h0);
    rate(16'h1F40);
    rd_chk("rate clamp", IDX_RATE_VALUE, {16'h0, RATE_MAX_RPM});
    clr();
  endtask : t_motion

  // Good save, reload after reset, then a failed save with slow store
  task automatic t_power();
    pfail();
    do_reset();
    rd_chk("usage saved", IDX_USAGE_COUNT, INIT + 3);
    steps(2 * SPR, 1'b1);
    rd_chk("usage run", IDX_USAGE_COUNT, INIT + 4);
    fail_save <= 1'b1;
    delay     <= 4'h9;
    pfail();
    rd_chk("usage back", IDX_USAGE_COUNT, INIT + 3);
    rd_chk("flag save", IDX_FAULT_FLAGS, 32'h10);
    clr();
    rd_chk("flag clear", IDX_FAULT_FLAGS, 32'h0);
  endtask : t_power

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard: far above the fewer than a thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, step_pulse, step_forward, power_fail, fail_save} = 8'h00;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    rate_sample = 16'h0000;
    delay       = 4'h1;
    do_reset();
    t_reset();
    t_usage();
    t_motion();
    t_power();
    final_report();
  end
endmodule : encoder_diagnostic_registers_tb
